// ==== design/piso_defs.vh ====
`ifndef PISO_DEFS_VH
`define PISO_DEFS_VH

// ------------------------------------------------------------
// register geometry
// ------------------------------------------------------------
`define PISO_WIDTH      8
`define PISO_RESET_VAL  8'h00
`define PISO_CLR_VAL    8'h00
`define PISO_LAST       7

// ------------------------------------------------------------
// mode select levels
// ------------------------------------------------------------
`define PISO_MODE_SHIFT 1'b1
`define PISO_MODE_LOAD  1'b0

// ------------------------------------------------------------
// shifts from serial input to serial output
// ------------------------------------------------------------
`define PISO_SHIFT_LATENCY 8

`endif

// ==== design/piso_shifter.v ====
// Summary of operation
// - shift select high: serial in, stages advance
// - shift select low: parallel inputs load stages
// - serial input ignored during parallel load
// - shift and load only on effective clock rising edge
// - either clock input high blocks clocking
// - either clock input may enable other
// - clear low forces all stages zero
// - serial bit reaches output after eight edges
`timescale 1ns/10ps
`default_nettype none
`include "piso_defs.vh"

module piso_shifter (
    input  wire                   clock,
    input  wire                   sys_rst,
    input  wire                   clearN,
    input  wire                   shiftSel,
    input  wire                   clkIn,
    input  wire                   clkInhibit,
    input  wire                   serialIn,
    input  wire [`PISO_WIDTH-1:0] parIn,
    output wire                   serialOut
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // all pins are sampled together so that clock and data stay aligned;
    // data therefore needs no setup beyond being valid at the sample that sees the clock edge
    wire [`PISO_WIDTH+4:0] pinSync;

    piso_sync #(
        .WIDTH (`PISO_WIDTH + 5)
    ) u_sync (
        .clock   (clock),
        .asyncIn ({clearN, shiftSel, clkIn, clkInhibit, serialIn, parIn}),
        .syncOut (pinSync)
    );

    wire                   clearNS    = pinSync[`PISO_WIDTH+4];
    wire                   shiftSelS  = pinSync[`PISO_WIDTH+3];
    wire                   clkInS     = pinSync[`PISO_WIDTH+2];
    wire                   clkInhS    = pinSync[`PISO_WIDTH+1];
    wire                   serialInS  = pinSync[`PISO_WIDTH];
    wire [`PISO_WIDTH-1:0] parInS     = pinSync[`PISO_WIDTH-1:0];

    // ------------------------------------------------------------
    // effective clock edge detect
    // ------------------------------------------------------------
    // nor of both clock pins; a high on either holds it low
    wire effClk = ~(clkInS | clkInhS);
    reg  effClkPrev_ff;

    always @(posedge clock) begin
        if (sys_rst) begin
            effClkPrev_ff <= 1'b1;
        end else begin
            effClkPrev_ff <= effClk;
        end
    end

    // rising edge of the nor is the only time the stages shift or load
    // limitation: an inhibit lowered while clkIn is low makes a real edge
    wire effRise = effClk & ~effClkPrev_ff;

    // ------------------------------------------------------------
    // stage register
    // ------------------------------------------------------------
    localparam OP_HOLD  = 2'b00;
    localparam OP_CLEAR = 2'b01;
    localparam OP_SHIFT = 2'b10;
    localparam OP_LOAD  = 2'b11;

    // one decode shared by every stage; clear outranks any clock edge
    function [1:0] stage_op;
        input clrN;
        input rise;
        input sel;
        begin
            if (!clrN) begin
                stage_op = OP_CLEAR;
            end else if (!rise) begin
                // no edge: hold, including zeros left by clear
                stage_op = OP_HOLD;
            end else if (sel == `PISO_MODE_SHIFT) begin
                stage_op = OP_SHIFT;
            end else begin
                stage_op = OP_LOAD;
            end
        end
    endfunction

    wire [1:0]             stageOp  = stage_op(clearNS, effRise, shiftSelS);
    wire [`PISO_WIDTH-1:0] clrVal   = `PISO_CLR_VAL;
    reg  [`PISO_WIDTH-1:0] stage_ff;
    wire [`PISO_WIDTH-1:0] nxt_stage;
    // stage one is bit 0, stage eight is bit 7
    wire [`PISO_WIDTH-1:0] shiftSrc = {stage_ff[`PISO_WIDTH-2:0], serialInS};

    genvar gi;
    generate
        for (gi = 0; gi < `PISO_WIDTH; gi = gi + 1) begin : g_stage
            reg nxt_bit;
            always @* begin
                case (stageOp)
                    OP_CLEAR: begin
                        nxt_bit = clrVal[gi];
                    end
                    OP_SHIFT: begin
                        nxt_bit = shiftSrc[gi];
                    end
                    OP_LOAD: begin
                        // serialInS not used here
                        nxt_bit = parInS[gi];
                    end
                    default: begin
                        nxt_bit = stage_ff[gi];
                    end
                endcase
            end
            assign nxt_stage[gi] = nxt_bit;
        end
    endgenerate

    always @(posedge clock) begin
        if (sys_rst) begin
            stage_ff <= `PISO_RESET_VAL;
        end else begin
            stage_ff <= nxt_stage;
        end
    end

    // only the last stage is visible
    assign serialOut = stage_ff[`PISO_LAST];

endmodule // piso_shifter

`default_nettype wire

// ==== design/piso_sync.v ====
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// two flip-flop synchroniser, one per bit
// ------------------------------------------------------------
module piso_sync #(
    parameter WIDTH = 1
) (
    input  wire             clock,
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    // first stage feeds only the second
    always @(posedge clock) begin
        meta_ff <= asyncIn;
        sync_ff <= meta_ff;
    end

    assign syncOut = sync_ff;

endmodule // piso_sync

`default_nettype wire

// ==== verif/piso_pin_drv.sv ====
`timescale 1ns/10ps
`default_nettype none
module piso_pin_drv (
    input  wire logic clock,
    output var  logic clkIn
);
    logic [2:0] cnt_ff = 3'h0;
    initial clkIn = 1'b1;
    // each pin level lasts 4 cycles so the design's synchroniser cannot miss it
    always @(negedge clock) begin
        cnt_ff <= cnt_ff + 3'h1;
        clkIn  <= cnt_ff[2];
    end
endmodule // piso_pin_drv
`default_nettype wire

// ==== verif/piso_shifter_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module piso_shifter_checker (
    input wire logic       clock, sys_rst, clearN, shiftSel, clkIn, clkInhibit, serialIn,
    input wire logic [7:0] parIn,
    input wire logic       serialOut
);
    wire effClk = !(clkIn | clkInhibit);
    logic [7:0] mir_ff;
    logic effPrev_ff;
    always @(posedge clock) begin
        effPrev_ff <= sys_rst | effClk;
        if (sys_rst | !clearN) mir_ff <= 8'h00;
        else if (effClk & !effPrev_ff) mir_ff <= shiftSel ? {mir_ff[6:0], serialIn} : parIn;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_clr; !clearN [*4] |-> !serialOut; endproperty
    a_clr: assert property (p_clr) else $error("clear not zero");
    property p_fall; $fell(clearN) |-> ##[1:4] !serialOut; endproperty
    a_fall: assert property (p_fall) else $error("clear late");
    property p_hold; (clearN && $stable(effClk)) [*6] |-> $stable(serialOut); endproperty
    a_hold: assert property (p_hold) else $error("change without edge");
    property p_inh; (clearN && clkInhibit) [*6] |-> $stable(serialOut); endproperty
    a_inh: assert property (p_inh) else $error("clocked while inhibited");
    property p_lod; $rose(effClk) && clearN && !shiftSel |-> ##3 serialOut == $past(parIn[7], 3); endproperty
    a_lod: assert property (p_lod) else $error("load wrong");
    property p_shf; $rose(effClk) && clearN && shiftSel |-> ##3 serialOut == mir_ff[7]; endproperty
    a_shf: assert property (p_shf) else $error("shift wrong");
    property p_out; (clearN && $stable(effClk)) [*6] |-> serialOut == mir_ff[7]; endproperty
    a_out: assert property (p_out) else $error("stage eight wrong");
    property p_aft; !clearN ##1 (clearN && !$rose(effClk)) [*6] |-> !serialOut; endproperty
    a_aft: assert property (p_aft) else $error("zeros lost");
    c_lod: cover property ($rose(effClk) && !shiftSel);
    c_shf: cover property ($rose(effClk) && shiftSel);
    c_clr: cover property ($fell(clearN));
endmodule // piso_shifter_checker
bind piso_shifter piso_shifter_checker u_chk (.clock, .sys_rst, .clearN, .shiftSel, .clkIn,
    .clkInhibit, .serialIn, .parIn, .serialOut);
`default_nettype wire

// ==== verif/piso_shifter_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module piso_shifter_tb_top;
    logic clock = 0, sys_rst = 1, clearN = 1, shiftSel = 0, clkInhibit = 1, serialIn = 0;
    logic [7:0] parIn = 8'h00;
    wire clkIn, serialOut;
    int err_count = 0, n_tests = 0;
    initial forever #2.5 clock = !clock;
    piso_pin_drv u_drv (.clock, .clkIn);
    piso_shifter dut (.clock, .sys_rst, .clearN, .shiftSel, .clkIn, .clkInhibit, .serialIn,
        .parIn, .serialOut);
    task automatic print_verdict;
        if (err_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic exp);
        n_tests++;
        if (serialOut !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, serialOut, exp);
        end
    endtask
    task automatic wt(input logic v);
        for (int i = 0; i < 20 && clkIn !== v; i++) @(negedge clock);
        if (clkIn !== v) begin
            err_count++;
            print_verdict;
        end
    endtask
    // data set while clkIn high, so it leads the effective rise (clkIn fall) by 4 cycles
    task automatic step;
        wt(1'b1);
        wt(1'b0);
        repeat (3) @(negedge clock);
    endtask
    task automatic t_stream(input logic [7:0] par, input logic [7:0] ser);
        {shiftSel, parIn, serialIn} = {1'b0, par, 1'b1};
        step;
        chk(par[7]);
        shiftSel = 1'b1;
        for (int k = 1; k < 16; k++) begin
            serialIn = (k <= 8) ? ser[k-1] : 1'b0;
            step;
            chk(k < 8 ? par[7-k] : ser[k-8]);
        end
    endtask
    task automatic t_gate;
        {shiftSel, parIn} = {1'b0, 8'h80};
        step;
        wt(1'b1);
        clkInhibit = 1'b1;
        {shiftSel, parIn} = {1'b0, 8'h00};
        repeat (24) @(negedge clock);
        chk(1'b1);
        {shiftSel, clearN} = 2'b10;
        repeat (8) @(negedge clock);
        chk(1'b0);
        clearN = 1'b1;
        repeat (16) @(negedge clock);
        chk(1'b0);
        wt(1'b1);
        clkInhibit = 1'b0;
        {shiftSel, parIn} = {1'b0, 8'h81};
        step;
        chk(1'b1);
    endtask
    initial begin
        repeat (16) @(negedge clock);
        sys_rst = 1'b0;
        wt(1'b1);
        clkInhibit = 1'b0;
        t_stream(8'h96, 8'h4d);
        t_stream(8'h69, 8'hb2);
        t_gate;
        print_verdict;
    end
endmodule // piso_shifter_tb_top
`default_nettype wire
